// file: design/sts_pkg.sv
package sts_pkg;

    // Progress codes
    localparam logic [7:0] PH_IDLE = 8'h00;
    localparam logic [7:0] PH_SEL = 8'h10;
    localparam logic [7:0] PH_IDENT_OUT = 8'h20;
    localparam logic [7:0] PH_TAGCODE_OUT = 8'h21;
    localparam logic [7:0] PH_QTAG_OUT = 8'h22;
    localparam logic [7:0] PH_CMD = 8'h30;
    localparam logic [7:0] PH_SDP = 8'h41;
    localparam logic [7:0] PH_DISC = 8'h42;
    localparam logic [7:0] PH_FREE = 8'h43;
    localparam logic [7:0] PH_RESEL = 8'h44;
    localparam logic [7:0] PH_IDENT_OK = 8'h45;
    localparam logic [7:0] PH_DATA_DONE = 8'h46;
    localparam logic [7:0] PH_STATUS = 8'h47;
    localparam logic [7:0] PH_STAT_OK = 8'h50;
    localparam logic [7:0] PH_CC = 8'h60;
    localparam logic [7:0] PH_TAG_EXP = 8'h70;
    localparam logic [7:0] PH_TAG_RCV = 8'h71;

    // Interrupt codes
    localparam logic [7:0] IRQ_UNEXP_MSG = 8'h4F;
    localparam logic [7:0] IRQ_DIFF_PROC = 8'h26;
    localparam logic [7:0] IRQ_STAT_PAR = 8'h47;
    localparam logic [7:0] IRQ_DONE = 8'h16;
    localparam logic [7:0] IRQ_DISC = 8'h85;
    localparam logic [7:0] IRQ_BUS_EVENT = 8'h41;
    localparam logic [7:0] IRQ_NONE = 8'h00;

    // Messages and fields
    localparam logic [7:0] MSG_CMD_CPLT = 8'h00;
    localparam logic [7:0] MSG_SDP = 8'h02;
    localparam logic [7:0] MSG_DISC = 8'h04;
    localparam logic [7:0] MSG_SIMPLE_TAG = 8'h20;
    localparam logic [7:0] IDENT_MASK = 8'hC7;
    localparam logic [7:0] IDENT_BASE = 8'h80;
    localparam int TAG_LSB = 3;

    // Register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DEST = 4'h1;
    localparam logic [3:0] REG_LUN = 4'h2;
    localparam logic [3:0] REG_QTAG = 4'h3;
    localparam logic [3:0] REG_CNT0 = 4'h4;
    localparam logic [3:0] REG_CNT1 = 4'h5;
    localparam logic [3:0] REG_PHASE = 4'h6;
    localparam logic [3:0] REG_IRQ = 4'h7;
    localparam logic [3:0] REG_CMD = 4'h8;
    localparam logic [3:0] REG_DATA = 4'h9;
    localparam int CTRL_EDI = 0;
    localparam int CTRL_IDI = 1;
    localparam int CTRL_HPE = 2;
    localparam logic [7:0] CMD_SEL_XFER = 8'h08;

    typedef struct packed {
        logic [7:0] data;
        logic parity_err;
        logic msg_in;
        logic status;
        logic data_ph;
    } sts_rx_t;

endpackage : sts_pkg

// file: design/sts_ident_check.sv
`timescale 1ns/10ps
module sts_ident_check
    import sts_pkg::*;
(
    // Received byte and expectation
    input wire logic [7:0] rx_byte,
    input wire logic [7:0] lun_reg,
    input wire logic [7:0] qtag_reg,
    // Verdicts
    output logic ident_ok,
    output logic simple_tag,
    output logic tag_match
);
    always_comb
    begin
        ident_ok = ((rx_byte & IDENT_MASK) ==
                    ((lun_reg & 8'h47) | IDENT_BASE));
        simple_tag = (rx_byte == MSG_SIMPLE_TAG);
        tag_match = (rx_byte == qtag_reg);
    end
endmodule : sts_ident_check

// file: design/sts_sequencer.sv
`timescale 1ns/10ps
module sts_sequencer
    import sts_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // Link events from bus engine
    input wire logic rx_valid,
    input wire sts_rx_t rx,
    input wire logic resel_match,
    input wire logic resel_other,
    input wire logic bus_free,
    input wire logic req_seen,
    input wire logic connected,
    // Data byte handshake and controls
    input wire logic data_ack,
    output logic data_xfer_en,
    output logic ack_release,
    output logic ack_hold,
    output logic irq,
    output logic [7:0] dma_mode
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_DATA = 3'b010,
        ST_WAIT_RESEL = 3'b011,
        ST_POST = 3'b100,
        ST_HALT = 3'b101
    } sts_state_t;

    sts_state_t state_q;
    logic [7:0] phase_q, ctrl_q, dest_q, lun_q, qtag_q, irq_code_q;
    logic [7:0] data_q;
    logic [CNT_W-1:0] cnt_q;
    logic irq_q, ack_rel_q, ack_hold_q, done_pend_q;
    logic ident_ok, simple_tag, tag_match, tag_exp, msg, go;

    sts_ident_check sts_ident_check_i (
        .rx_byte(rx.data),
        .lun_reg(lun_q),
        .qtag_reg(qtag_q),
        .ident_ok(ident_ok),
        .simple_tag(simple_tag),
        .tag_match(tag_match)
    );

    assign tag_exp = |dest_q[TAG_LSB+1:TAG_LSB];
    assign msg = rx_valid && rx.msg_in;
    assign go = wr_stb && addr == REG_CMD && wdata == CMD_SEL_XFER;
    assign data_xfer_en = (state_q == ST_DATA);
    assign dma_mode = ctrl_q;
    assign ack_release = ack_rel_q;
    assign ack_hold = ack_hold_q;
    assign irq = irq_q;

    // Software-written configuration
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_q <= 8'h00;
            dest_q <= 8'h00;
        end
        else if (wr_stb)
        begin
            if (addr == REG_CTRL)
                ctrl_q <= wdata;
            if (addr == REG_DEST)
                dest_q <= wdata;
        end
    end

    // Last received byte, kept for the host
    always_ff @(posedge clock)
    begin
        if (srst)
            data_q <= 8'h00;
        else if (rx_valid)
            data_q <= rx.data;
    end

    // Sequencer: phase code, counts, interrupts
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            phase_q <= PH_IDLE;
            lun_q <= 8'h00;
            qtag_q <= 8'h00;
            cnt_q <= '0;
            irq_q <= 1'b0;
            irq_code_q <= IRQ_NONE;
            ack_rel_q <= 1'b0;
            ack_hold_q <= 1'b0;
            done_pend_q <= 1'b0;
        end
        else
        begin
            ack_rel_q <= 1'b0;
            if (wr_stb && addr == REG_LUN)
                lun_q <= wdata;
            if (wr_stb && addr == REG_QTAG)
                qtag_q <= wdata;
            if (wr_stb && addr == REG_CNT0)
                cnt_q[7:0] <= wdata;
            if (wr_stb && addr == REG_CNT1)
                cnt_q[CNT_W-1:8] <= wdata[CNT_W-9:0];
            if (wr_stb && addr == REG_PHASE)
                phase_q <= wdata;
            // Reading the code acknowledges the interrupt
            if (rd_stb && addr == REG_IRQ)
                irq_q <= 1'b0;
            if (go && connected)
            begin
                // Resume point from current code
                state_q <= ST_RUN;
                ack_hold_q <= 1'b0;
                unique case (phase_q)
                    PH_IDENT_OUT, PH_QTAG_OUT, PH_SDP, PH_DISC,
                    PH_IDENT_OK, PH_STAT_OK, PH_CC, PH_TAG_EXP:
                        ack_rel_q <= 1'b1;
                    default:
                        ack_rel_q <= 1'b0;
                endcase
                if (phase_q == PH_IDENT_OK && cnt_q != '0)
                    state_q <= ST_DATA;
            end
            else if (go)
            begin
                state_q <= ST_RUN;
                phase_q <= PH_SEL;
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE:
                    begin
                    end
                    ST_RUN, ST_DATA:
                    begin
                        if (state_q == ST_DATA && rx_valid && rx.data_ph)
                        begin
                            // Held in data phase until count drains
                        end
                        if (state_q == ST_DATA && data_ack)
                        begin
                            cnt_q <= cnt_q - 1'b1;
                            if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1})
                            begin
                                phase_q <= PH_DATA_DONE;
                                state_q <= ST_RUN;
                            end
                        end
                        if (phase_q == PH_RESEL && msg)
                        begin
                            if (!ident_ok)
                            begin
                                irq_q <= 1'b1;
                                irq_code_q <= IRQ_UNEXP_MSG;
                                state_q <= ST_HALT;
                            end
                            else if (tag_exp)
                                phase_q <= PH_TAG_EXP;
                            else
                            begin
                                phase_q <= PH_IDENT_OK;
                                if (cnt_q != '0)
                                    state_q <= ST_DATA;
                            end
                        end
                        else if (phase_q == PH_TAG_EXP && msg)
                        begin
                            if (simple_tag)
                                phase_q <= phase_q + 8'h01;
                            else
                            begin
                                irq_q <= 1'b1;
                                irq_code_q <= IRQ_UNEXP_MSG;
                                state_q <= ST_HALT;
                            end
                        end
                        else if (phase_q == PH_TAG_RCV && msg)
                        begin
                            phase_q <= PH_IDENT_OK;
                            if (!tag_match)
                            begin
                                qtag_q <= rx.data;
                                irq_q <= 1'b1;
                                irq_code_q <= IRQ_DIFF_PROC;
                                state_q <= ST_HALT;
                            end
                            else if (cnt_q != '0)
                                state_q <= ST_DATA;
                        end
                        else if (rx_valid && rx.status && cnt_q == '0)
                        begin
                            phase_q <= PH_STATUS;
                            if (rx.parity_err && ctrl_q[CTRL_HPE])
                            begin
                                irq_q <= 1'b1;
                                irq_code_q <= IRQ_STAT_PAR;
                                ack_hold_q <= 1'b1;
                                state_q <= ST_HALT;
                            end
                            else
                            begin
                                lun_q <= rx.data;
                                phase_q <= PH_STAT_OK;
                            end
                        end
                        else if (msg && rx.data == MSG_CMD_CPLT &&
                                 phase_q == PH_STAT_OK)
                        begin
                            phase_q <= PH_CC;
                            state_q <= ST_POST;
                            if (!ctrl_q[CTRL_EDI])
                            begin
                                irq_q <= 1'b1;
                                irq_code_q <= IRQ_DONE;
                            end
                            else
                                done_pend_q <= 1'b1;
                        end
                        else if (msg && rx.data == MSG_SDP)
                        begin
                            phase_q <= PH_SDP;
                            irq_q <= 1'b1;
                            irq_code_q <= IRQ_DISC;
                            state_q <= ST_HALT;
                        end
                        else if (msg && rx.data == MSG_DISC)
                        begin
                            phase_q <= PH_DISC;
                            state_q <= ST_WAIT_RESEL;
                        end
                    end
                    ST_WAIT_RESEL:
                    begin
                        if (phase_q == PH_DISC && bus_free)
                        begin
                            phase_q <= PH_FREE;
                            // Data still owed or CTRL_IDI set: interrupt the host to reload DMA
                            if (ctrl_q[CTRL_IDI] || cnt_q != '0)
                            begin
                                irq_q <= 1'b1;
                                irq_code_q <= IRQ_DISC;
                                // Stays armed so the reconnect still lands
                            end
                        end
                        else if (phase_q == PH_FREE && resel_match)
                        begin
                            phase_q <= PH_RESEL;
                            state_q <= ST_RUN;
                        end
                        // Foreign reselection ends the command
                        else if (phase_q == PH_FREE && resel_other)
                        begin
                            irq_q <= 1'b1;
                            irq_code_q <= IRQ_UNEXP_MSG;
                            state_q <= ST_HALT;
                        end
                    end
                    ST_POST:
                    begin
                        // Held completion waits for the bus to go free
                        if (bus_free || (req_seen && !done_pend_q))
                        begin
                            irq_q <= 1'b1;
                            irq_code_q <= done_pend_q ? IRQ_DONE
                                                      : IRQ_BUS_EVENT;
                            done_pend_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_HALT:
                    begin
                        // Command ended; waits for host resume
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Register read port, one cycle latency
    always_ff @(posedge clock)
    begin
        if (srst)
            rdata <= 8'h00;
        else if (rd_stb)
        begin
            unique case (addr)
                REG_CTRL: rdata <= ctrl_q;
                REG_DEST: rdata <= dest_q;
                REG_LUN: rdata <= lun_q;
                REG_QTAG: rdata <= qtag_q;
                REG_CNT0: rdata <= cnt_q[7:0];
                REG_CNT1: rdata <= 8'(cnt_q >> 8);
                REG_PHASE: rdata <= phase_q;
                REG_IRQ: rdata <= irq_code_q;
                REG_DATA: rdata <= data_q;
                default: rdata <= 8'h00;
            endcase
        end
    end
endmodule : sts_sequencer

// file: verification/sts_target_model.sv
`timescale 1ns/10ps
module sts_target_model
    import sts_pkg::*;
(
    // Clock and sequencer state
    input wire logic clock,
    input wire logic data_xfer_en,
    // Bus events toward the sequencer
    output logic rx_valid = 1'b0,
    output sts_rx_t rx = '0,
    output logic resel_match = 1'b0,
    output logic resel_other = 1'b0,
    output logic bus_free = 1'b0,
    output logic req_seen = 1'b0,
    output logic connected,
    output logic data_ack
);
    logic conn = 1'b0;
    logic slow = 1'b0;
    int lim = 0;
    int acks = 0;
    assign connected = conn;
    // Released data is turned over so a stale byte never looks valid
    task automatic send(input logic [7:0] d, input logic st,
        input logic pe);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx <= '{d, pe, !st, st, 1'b0};
        @(posedge clock);
        rx_valid <= 1'b0;
        rx.data <= ~d;
    endtask : send
    // Order: resel_match, bus_free, req_seen, resel_other
    task automatic pulse(input logic [3:0] m);
        @(posedge clock);
        {resel_match, bus_free, req_seen, resel_other} <= m;
        @(posedge clock);
        {resel_match, bus_free, req_seen, resel_other} <= 4'h0;
    endtask : pulse
    // Acks stop at lim, so a scenario can stall the target mid-block
    always_ff @(posedge clock)
    begin
        data_ack <= data_xfer_en && (acks + int'(data_ack)) < lim
            && !(slow && data_ack);
        acks <= acks + int'(data_ack);
    end
endmodule : sts_target_model

// file: verification/sts_sequencer_properties.sv
`timescale 1ns/10ps
module sts_sequencer_properties
    import sts_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // Clock, reset, register port, link
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rx_valid,
    input wire sts_rx_t rx,
    input wire logic bus_free,
    // Watched outputs
    input wire logic data_xfer_en,
    input wire logic ack_release,
    input wire logic ack_hold,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic [7:0] ctrl_q;
    // Shadow of the control bits the rules depend on
    always_ff @(posedge clock)
    begin
        if (srst)
            ctrl_q <= 8'h00;
        else if (wr_stb && addr == REG_CTRL)
            ctrl_q <= wdata;
    end
    sequence s_cc;
        rx_valid && rx.msg_in && rx.data == MSG_CMD_CPLT;
    endsequence
    sequence s_disc;
        rx_valid && rx.msg_in && rx.data == MSG_DISC && data_xfer_en;
    endsequence
    property p_rst_quiet;
        disable iff (1'b0) srst |=> !irq && !ack_hold && !data_xfer_en;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active after reset");
    property p_rel_cause;
        $rose(ack_release) |->
            $past(wr_stb && addr == REG_CMD && wdata == CMD_SEL_XFER);
    endproperty
    a_rel_cause: assert property (p_rel_cause)
        else $error("ack release without resume");
    property p_rel_pulse;
        ack_release |=> !ack_release;
    endproperty
    a_rel_pulse: assert property (p_rel_pulse)
        else $error("ack release longer than a cycle");
    property p_hold_cause;
        $rose(ack_hold) |-> irq && $past(rx_valid && rx.status
            && rx.parity_err && ctrl_q[CTRL_HPE]);
    endproperty
    a_hold_cause: assert property (p_hold_cause)
        else $error("ack hold without status parity halt");
    property p_done_irq;
        s_cc ##0 !ctrl_q[CTRL_EDI] |=> irq;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("no completion interrupt");
    property p_edi_hold;
        s_cc ##0 ctrl_q[CTRL_EDI] |=> !irq;
    endproperty
    a_edi_hold: assert property (p_edi_hold)
        else $error("completion interrupt not held back");
    property p_free_irq;
        s_cc ##[1:40] bus_free |=> irq;
    endproperty
    a_free_irq: assert property (p_free_irq)
        else $error("no interrupt on bus free");
    property p_disc_irq;
        s_disc ##[1:20] bus_free |=> irq;
    endproperty
    a_disc_irq: assert property (p_disc_irq)
        else $error("no interrupt on data disconnect");
endmodule : sts_sequencer_properties
bind sts_sequencer sts_sequencer_properties #(.CNT_W(CNT_W))
    sts_sequencer_properties_i (.clock(clock), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rx_valid(rx_valid), .rx(rx),
    .bus_free(bus_free), .data_xfer_en(data_xfer_en),
    .ack_release(ack_release), .ack_hold(ack_hold), .irq(irq));

// file: verification/test_scsi_select_transfer_sequencer.sv
`timescale 1ns/10ps
module test_scsi_select_transfer_sequencer
    import sts_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata, dma_mode;
    sts_rx_t rx;
    logic rx_valid, resel_match, resel_other, bus_free, req_seen;
    logic connected, data_ack, data_xfer_en, ack_release, ack_hold, irq;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    initial
    begin
        forever #50 clock = ~clock;
    end
    sts_sequencer #(.CNT_W(16)) sts_sequencer_i (.clock(clock),
        .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .rx_valid(rx_valid), .rx(rx),
        .resel_match(resel_match), .resel_other(resel_other),
        .bus_free(bus_free), .req_seen(req_seen), .connected(connected),
        .data_ack(data_ack), .data_xfer_en(data_xfer_en),
        .ack_release(ack_release), .ack_hold(ack_hold), .irq(irq),
        .dma_mode(dma_mode));
    sts_target_model sts_target_model_i (.clock(clock),
        .data_xfer_en(data_xfer_en), .rx_valid(rx_valid), .rx(rx),
        .resel_match(resel_match), .resel_other(resel_other),
        .bus_free(bus_free), .req_seen(req_seen), .connected(connected),
        .data_ack(data_ack));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic chkr(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 chk(rdata, e);
    endtask : chkr
    // Pulse is one cycle wide, so look from the launch edge onward
    task automatic resume(input logic [7:0] c, input logic rel);
        logic saw;
        saw = 1'b0;
        wr(REG_PHASE, c);
        wr(REG_CMD, CMD_SEL_XFER);
        repeat (3)
        begin
            #1 saw |= ack_release;
            @(posedge clock);
        end
        chk({7'h00, saw}, {7'h00, rel});
    endtask : resume
    task automatic t_flow(input logic edi);
        int a0;
        a0 = sts_target_model_i.acks;
        wr(REG_CTRL, {7'h00, edi});
        wr(REG_DEST, 8'h08);
        wr(REG_LUN, 8'h03);
        wr(REG_QTAG, 8'h5A);
        wr(REG_CNT0, 8'h03);
        wr(REG_CNT1, 8'h00);
        chk(dma_mode, {7'h00, edi});
        sts_target_model_i.slow = 1'b0;
        sts_target_model_i.lim = a0 + 1;
        resume(PH_IDENT_OK, 1'b1);
        repeat (6) @(posedge clock);
        chk({7'h00, data_xfer_en}, 8'h01);
        sts_target_model_i.send(MSG_DISC, 1'b0, 1'b0);
        sts_target_model_i.pulse(4'h4);
        chkr(REG_IRQ, IRQ_DISC);
        chkr(REG_PHASE, PH_FREE);
        sts_target_model_i.slow = 1'b1;
        sts_target_model_i.lim = a0 + 3;
        sts_target_model_i.pulse(4'h8);
        chkr(REG_PHASE, PH_RESEL);
        sts_target_model_i.send(8'h83, 1'b0, 1'b0);
        chkr(REG_PHASE, PH_TAG_EXP);
        sts_target_model_i.send(MSG_SIMPLE_TAG, 1'b0, 1'b0);
        chkr(REG_PHASE, PH_TAG_RCV);
        sts_target_model_i.send(8'h5A, 1'b0, 1'b0);
        for (int k = 0; k < 60; k++)
        begin
            if (sts_target_model_i.acks == a0 + 3 && !data_xfer_en)
                break;
            @(posedge clock);
        end
        chk(8'(sts_target_model_i.acks - a0), 8'h03);
        chkr(REG_PHASE, PH_DATA_DONE);
        sts_target_model_i.send(8'h02, 1'b1, 1'b0);
        chkr(REG_PHASE, PH_STAT_OK);
        chkr(REG_LUN, 8'h02);
        sts_target_model_i.send(MSG_CMD_CPLT, 1'b0, 1'b0);
        chkr(REG_PHASE, PH_CC);
        chk({7'h00, irq}, {7'h00, !edi});
        if (!edi)
            chkr(REG_IRQ, IRQ_DONE);
        sts_target_model_i.pulse(4'h4);
        chkr(REG_IRQ, edi ? IRQ_DONE : IRQ_BUS_EVENT);
        $display("flow test ended");
    endtask : t_flow
    task automatic t_ident();
        wr(REG_DEST, 8'h00);
        wr(REG_LUN, 8'h03);
        wr(REG_CNT0, 8'h01);
        sts_target_model_i.lim = sts_target_model_i.acks;
        resume(PH_RESEL, 1'b0);
        sts_target_model_i.send(8'h84, 1'b0, 1'b0);
        chkr(REG_IRQ, IRQ_UNEXP_MSG);
        chkr(REG_DATA, 8'h84);
        chkr(4'hF, 8'h00);
        resume(PH_RESEL, 1'b0);
        sts_target_model_i.send(8'h83, 1'b0, 1'b0);
        chkr(REG_PHASE, PH_IDENT_OK);
        sts_target_model_i.lim = sts_target_model_i.acks + 1;
        repeat (6) @(posedge clock);
        chkr(REG_PHASE, PH_DATA_DONE);
        resume(PH_IDENT_OK, 1'b1);
        $display("identify test ended");
    endtask : t_ident
    task automatic t_tag();
        logic [7:0] bad [2] = '{8'h21, MSG_DISC};
        wr(REG_DEST, 8'h08);
        foreach (bad[i])
        begin
            resume(PH_TAG_EXP, 1'b1);
            sts_target_model_i.send(bad[i], 1'b0, 1'b0);
            chkr(REG_IRQ, IRQ_UNEXP_MSG);
        end
        resume(PH_TAG_EXP, 1'b1);
        sts_target_model_i.send(MSG_SIMPLE_TAG, 1'b0, 1'b0);
        chkr(REG_PHASE, PH_TAG_RCV);
        sts_target_model_i.send(8'h66, 1'b0, 1'b0);
        chkr(REG_IRQ, IRQ_DIFF_PROC);
        chkr(REG_QTAG, 8'h66);
        chkr(REG_PHASE, PH_IDENT_OK);
        resume(PH_IDENT_OK, 1'b1);
        sts_target_model_i.send(MSG_SDP, 1'b0, 1'b0);
        chkr(REG_IRQ, IRQ_DISC);
        chkr(REG_PHASE, PH_SDP);
        $display("tag test ended");
    endtask : t_tag
    // Which resume codes release ACK, first code in the top bit
    task automatic t_resume();
        logic [7:0] c [12] = '{8'h10, 8'h20, 8'h22, 8'h30, 8'h41, 8'h42,
            8'h44, 8'h45, 8'h46, 8'h50, 8'h60, 8'h70};
        logic [11:0] r = 12'b011011010111;
        foreach (c[i])
            resume(c[i], r[11 - i]);
        $display("resume test ended");
    endtask : t_resume
    task automatic t_parity();
        wr(REG_CTRL, 8'h04);
        resume(PH_DATA_DONE, 1'b0);
        sts_target_model_i.send(8'h02, 1'b1, 1'b1);
        chkr(REG_IRQ, IRQ_STAT_PAR);
        chk({7'h00, ack_hold}, 8'h01);
        chkr(REG_PHASE, PH_STATUS);
        @(posedge clock);
        srst <= 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        #1 chk({7'h00, ack_hold}, 8'h00);
        chkr(REG_PHASE, PH_IDLE);
        $display("parity test ended");
    endtask : t_parity
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        sts_target_model_i.conn <= 1'b1;
        t_flow(1'b0);
        t_flow(1'b1);
        t_ident();
        t_tag();
        t_resume();
        t_parity();
        tally_and_finish();
    end
endmodule : test_scsi_select_transfer_sequencer
